// *** core/lasm_top.sv ***
`default_nettype none

module lasm_top
    import lasm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        mono_range,
    input  wire logic [9:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [13:0] buf_addr,
    input  wire logic [7:0]  buf_wdata,
    input  wire logic        buf_wr,
    input  wire logic        buf_rd,
    output logic      [7:0]  buf_rdata,
    output logic      [1:0]  pel_shade,
    output logic             pel_valid,
    output logic             line_start,
    output logic             frame_start
);

    // ---------------- registers ----------------
    logic [7:0]  mode_q;
    logic [11:0] font_ptr_q;
    logic [7:0]  reg_rdata_q;
    logic [7:0]  font_mem [4096];

    wire [9:0] base_w   = mono_range ? MONO_BASE : COLOR_BASE;
    wire       hit_w    = (reg_addr[9:4] == base_w[9:4]); // see R21
    wire [3:0] off_w    = reg_addr[3:0];
    wire       wr_mode  = reg_wr && hit_w && (off_w == REG_MODE);
    wire       wr_flo   = reg_wr && hit_w && (off_w == REG_FONT_LO);
    wire       wr_fhi   = reg_wr && hit_w && (off_w == REG_FONT_HI);
    wire       wr_fdat  = reg_wr && hit_w && (off_w == REG_FONT_DATA);

    wire       gfx_w    = mode_q[MODE_GFX_BIT];
    wire       mono_w   = mode_q[MODE_MONO_BIT];
    wire       video_w  = mode_q[MODE_VIDEO_BIT];
    wire [1:0] imap_w   = mode_q[MODE_IMAP_LSB +: 2];

    // ---------------- raster counters ----------------
    logic [9:0] h_q;
    logic [8:0] v_q;

    wire h_end_w  = (h_q == 10'(H_TOTAL - 1));
    wire v_end_w  = (v_q == 9'(V_TOTAL - 1));
    wire active_w = (h_q < 10'(H_ACTIVE)) && (v_q < 9'(V_ACTIVE)); // see R7
    wire vblank_w = (v_q >= 9'(V_ACTIVE));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            h_q <= 10'h000;
            v_q <= 9'h000;
        end else begin
            h_q <= h_end_w ? 10'h000 : h_q + 10'h001;
            if (h_end_w) begin
                v_q <= v_end_w ? 9'h000 : v_q + 9'h001;
            end
        end
    end

    wire [7:0] status_w = {5'h00, gfx_w, vblank_w, active_w};

    wire [7:0] rd_mux_w = (off_w == REG_MODE)    ? mode_q :
                          (off_w == REG_STATUS)  ? status_w :
                          (off_w == REG_FONT_LO) ? font_ptr_q[7:0] :
                          (off_w == REG_FONT_HI) ? {4'h0, font_ptr_q[11:8]} :
                          (off_w == REG_LINE)    ? v_q[7:0] :
                          8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q      <= MODE_RESET;
            font_ptr_q  <= 12'h000;
            reg_rdata_q <= 8'h00;
        end else begin
            if (wr_mode) begin
                mode_q <= reg_wdata;
            end
            if (wr_flo) begin
                font_ptr_q[7:0] <= reg_wdata;
            end else if (wr_fhi) begin
                font_ptr_q[11:8] <= reg_wdata[3:0];
            end else if (wr_fdat) begin
                font_ptr_q <= font_ptr_q + 12'h001;
            end
            reg_rdata_q <= (reg_rd && hit_w) ? rd_mux_w : 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // font index bit 11 picks main or alternate font
    always_ff @(posedge clock) begin
        if (wr_fdat) begin
            font_mem[font_ptr_q] <= reg_wdata; // see R20
        end
    end

    // ---------------- stage 0: fetch address ----------------
    // text: one word per 8x8 cell, 80 cells per row
    wire [4:0]  row_w     = v_q[7:3];
    wire [6:0]  col_w     = h_q[9:3];
    wire [12:0] cell_w    = 13'({row_w, 6'h00}) + 13'({row_w, 4'h0}) + 13'(col_w); // see R12
    // graphics: 80 bytes per line, four 2-bit pels per byte
    wire [13:0] gbyte_w   = 14'({v_q[7:0], 6'h00}) + 14'({v_q[7:0], 4'h0}) + 14'(col_w);
    wire [12:0] disp_addr = gfx_w ? gbyte_w[13:1] : cell_w;
    wire [15:0] disp_word;

    lasm_refresh_buf u_buf (
        .clock     (clock),
        .rst       (rst),
        .buf_addr  (buf_addr),
        .buf_wdata (buf_wdata),
        .buf_wr    (buf_wr),
        .buf_rd    (buf_rd),
        .buf_rdata (buf_rdata),
        .disp_addr (disp_addr),
        .disp_word (disp_word)
    );

    // ---------------- stage 1: word present ----------------
    logic [2:0] s1_x_q;
    logic [2:0] s1_y_q;
    logic       s1_act_q;
    logic       s1_odd_q;
    logic       s1_first_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_x_q     <= 3'h0;
            s1_y_q     <= 3'h0;
            s1_act_q   <= 1'b0;
            s1_odd_q   <= 1'b0;
            s1_first_q <= 1'b0;
        end else begin
            s1_x_q     <= h_q[2:0];
            s1_y_q     <= v_q[2:0];
            s1_act_q   <= active_w;
            s1_odd_q   <= gbyte_w[0];
            s1_first_q <= (h_q == 10'h000);
        end
    end

    wire [7:0]  s1_char_w = disp_word[7:0];  // see R17
    wire [7:0]  s1_attr_w = disp_word[15:8];
    wire        alt_w     = s1_attr_w[ATTR_INT_BIT] && (imap_w == IMAP_ALTFONT); // see R15
    wire [11:0] font_rd_w = {alt_w, s1_char_w, s1_y_q};

    // ---------------- stage 2: glyph row present ----------------
    logic [7:0] s2_glyph_q;
    logic [7:0] s2_attr_q;
    logic [7:0] s2_gbyte_q;
    logic [2:0] s2_x_q;
    logic [2:0] s2_y_q;
    logic       s2_act_q;
    logic       s2_first_q;
    logic       s2_top_q;

    always_ff @(posedge clock) begin
        s2_glyph_q <= font_mem[font_rd_w];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s2_attr_q  <= 8'h00;
            s2_gbyte_q <= 8'h00;
            s2_x_q     <= 3'h0;
            s2_y_q     <= 3'h0;
            s2_act_q   <= 1'b0;
            s2_first_q <= 1'b0;
            s2_top_q   <= 1'b0;
        end else begin
            s2_attr_q  <= s1_attr_w;
            s2_gbyte_q <= s1_odd_q ? disp_word[15:8] : disp_word[7:0];
            s2_x_q     <= s1_x_q;
            s2_y_q     <= s1_y_q;
            s2_act_q   <= s1_act_q;
            s2_first_q <= s1_first_q && s1_act_q;
            s2_top_q   <= s1_first_q && s1_act_q && (v_q == 9'h000);
        end
    end

    wire       glyph_on_w = s2_glyph_q[3'h7 - s2_x_q];
    wire [1:0] text_shade;

    lasm_text_shade u_shade (
        .attr          (s2_attr_q),
        .glyph_on      (glyph_on_w),
        .underline_row (s2_y_q == UNDERLINE_ROW),
        .mono_mode     (mono_w),
        .imap          (imap_w),
        .shade         (text_shade)
    );

    // leftmost pel of a graphics byte sits in its top two bits
    wire [1:0] gpix_w  = s2_gbyte_q[{~s2_x_q[2:1], 1'b0} +: 2];
    wire [1:0] gshade_w = (gpix_w == 2'h0) ? SHADE_GRAY  :
                          (gpix_w == 2'h1) ? SHADE_DARK1 :
                          (gpix_w == 2'h2) ? SHADE_DARK2 : SHADE_BLACK; // see R6
    // blanking holds the panel at gray but fetching never stops
    wire [1:0] shade_d = (!s2_act_q || !video_w) ? SHADE_GRAY :
                         gfx_w ? gshade_w : text_shade; // see R10

    // ---------------- stage 3: panel outputs ----------------
    logic [1:0] pel_shade_q;
    logic       pel_valid_q;
    logic       line_start_q;
    logic       frame_start_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pel_shade_q   <= SHADE_GRAY;
            pel_valid_q   <= 1'b0;
            line_start_q  <= 1'b0;
            frame_start_q <= 1'b0;
        end else begin
            pel_shade_q   <= shade_d;
            pel_valid_q   <= s2_act_q; // see R7
            line_start_q  <= s2_first_q;
            frame_start_q <= s2_top_q;
        end
    end

    assign pel_shade   = pel_shade_q;
    assign pel_valid   = pel_valid_q;
    assign line_start  = line_start_q;
    assign frame_start = frame_start_q;

    // ---------------- checks ----------------
    wire [2:0] a_fg = s2_attr_q[ATTR_FG_LSB +: 3];
    wire [2:0] a_bg = s2_attr_q[ATTR_BG_LSB +: 3];
    wire       a_text_on = s2_act_q && video_w && !gfx_w && !mono_w
                           && (imap_w == IMAP_IGNORE);

    normal_cell_a: assert property (@(posedge clock) disable iff (rst) // see R1 R14
        a_text_on && a_fg == COLOR_WHITE && a_bg == COLOR_BLACK
        |=> pel_shade == ($past(glyph_on_w) ? SHADE_BLACK : SHADE_GRAY))
        else $error("white on black cell not normal video");

    reverse_cell_a: assert property (@(posedge clock) disable iff (rst) // see R2 R3
        a_text_on && a_fg != a_bg && !(a_fg == COLOR_WHITE && a_bg == COLOR_BLACK)
        && s2_y_q != UNDERLINE_ROW
        |=> pel_shade == ($past(glyph_on_w) ? SHADE_GRAY : SHADE_BLACK))
        else $error("differing colour cell not reverse video");

    solid_cell_a: assert property (@(posedge clock) disable iff (rst) // see R4
        a_text_on && a_fg == a_bg && a_fg != COLOR_BLACK |=> pel_shade == SHADE_BLACK)
        else $error("equal colour cell not solid block");

    hidden_cell_a: assert property (@(posedge clock) disable iff (rst) // see R5
        a_text_on && a_fg == COLOR_BLACK && a_bg == COLOR_BLACK |=> pel_shade == SHADE_GRAY)
        else $error("black on black cell not hidden");

    // unwritten graphics bytes are unknown, so code 0 and codes 1..3 get their own antecedents
    gfx_shade_a: assert property (@(posedge clock) disable iff (rst) // see R6
        s2_act_q && video_w && gfx_w && gpix_w != 2'h0
        |=> pel_shade == ($past(gpix_w) == 2'h1 ? SHADE_DARK1 :
                          $past(gpix_w) == 2'h2 ? SHADE_DARK2 : SHADE_BLACK))
        else $error("graphics pel shade wrong");

    gfx_bg_a: assert property (@(posedge clock) disable iff (rst) // see R6
        s2_act_q && video_w && gfx_w && gpix_w == 2'h0 |=> pel_shade == SHADE_GRAY)
        else $error("graphics background not gray");

    area_wrap_a: assert property (@(posedge clock) disable iff (rst) // see R7
        h_end_w && v_q < 9'(V_ACTIVE - 1)
        |=> h_q == 10'h000 ##3 (pel_valid && line_start))
        else $error("raster does not restart at first pel");

    video_off_a: assert property (@(posedge clock) disable iff (rst) // see R10
        !video_w [*3] |=> pel_shade == SHADE_GRAY)
        else $error("blanked panel not gray");

    buf_echo_a: assert property (@(posedge clock) disable iff (rst) // see R8 R9
        buf_wr ##1 (buf_rd && buf_addr == $past(buf_addr))
        |=> buf_rdata == $past(buf_wdata, 2))
        else $error("buffer read does not return written byte");

    reg_decode_a: assert property (@(posedge clock) disable iff (rst) // see R21
        reg_rd && hit_w && off_w == REG_MODE && !reg_wr |=> reg_rdata == mode_q)
        else $error("mode register not read back");

    alt_font_a: assert property (@(posedge clock) disable iff (rst) // see R15 R20
        s1_act_q && s1_attr_w[ATTR_INT_BIT] && imap_w == IMAP_ALTFONT
        |=> s2_glyph_q == font_mem[{1'b1, $past(s1_char_w), $past(s1_y_q)}])
        else $error("alternate font not selected");

    text_cover_c: cover property (@(posedge clock) disable iff (rst)
        a_text_on && a_fg == COLOR_WHITE && a_bg == COLOR_BLACK ##1 pel_shade == SHADE_BLACK);
    gfx_cover_c: cover property (@(posedge clock) disable iff (rst)
        gfx_w && pel_valid && pel_shade == SHADE_DARK2);
    busy_cover_c: cover property (@(posedge clock) disable iff (rst)
        buf_wr && active_w ##1 buf_rd);
    frame_cover_c: cover property (@(posedge clock) disable iff (rst) frame_start);

endmodule

`default_nettype wire

// *** core/lasm_pkg.sv ***
// Operation
// R1: white on black text is normal video
// R2: black on white text is reverse video
// R3: other differing colour pairs show reverse video
// R4: equal non-black colours show solid reverse block
// R5: black on black hides the character
// R6: graphics codes map to gray and dark shades
// R7: active area is 640 by 200 pels
// R8: host buffer access never disturbs displayed image
// R9: host buffer access accepted at any moment
// R10: buffer access works with video enabled
// R11: software avoids toggling video during updates
// R12: monochrome emulation uses 8 by 8 cells
// R13: colour text emulation shows only two colours
// R14: intensity bit never changes character darkness
// R15: intensity shown as underscore, reverse, font, none
// R16: three-bit colour codes black through white
// R17: character at even byte, attribute at odd
// R18: attribute bits blink, background, intensity, foreground
// R19: monochrome attribute table for five fixed pairs
// R20: two RAM fonts, main and alternate
// R21: registers decode at one of two ranges
`default_nettype none

package lasm_pkg;

    localparam int H_ACTIVE   = 640;
    localparam int V_ACTIVE   = 200;
    localparam int H_TOTAL    = 800;
    localparam int V_TOTAL    = 262;
    localparam int TEXT_COLS  = 80;

    localparam logic [9:0] COLOR_BASE = 10'h1D0;
    localparam logic [9:0] MONO_BASE  = 10'h1B0;

    localparam logic [3:0] REG_MODE      = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h1;
    localparam logic [3:0] REG_FONT_LO   = 4'h2;
    localparam logic [3:0] REG_FONT_HI   = 4'h3;
    localparam logic [3:0] REG_FONT_DATA = 4'h4;
    localparam logic [3:0] REG_LINE      = 4'h5;

    localparam int MODE_GFX_BIT   = 0;
    localparam int MODE_MONO_BIT  = 1;
    localparam int MODE_VIDEO_BIT = 2;
    localparam int MODE_IMAP_LSB  = 3;
    localparam logic [7:0] MODE_RESET = 8'h04;

    localparam int ATTR_BLINK_BIT = 7;
    localparam int ATTR_BG_LSB    = 4;
    localparam int ATTR_INT_BIT   = 3;
    localparam int ATTR_FG_LSB    = 0;

    localparam logic [2:0] COLOR_BLACK   = 3'h0;
    localparam logic [2:0] COLOR_BLUE    = 3'h1;
    localparam logic [2:0] COLOR_GREEN   = 3'h2;
    localparam logic [2:0] COLOR_CYAN    = 3'h3;
    localparam logic [2:0] COLOR_RED     = 3'h4;
    localparam logic [2:0] COLOR_MAGENTA = 3'h5;
    localparam logic [2:0] COLOR_BROWN   = 3'h6;
    localparam logic [2:0] COLOR_WHITE   = 3'h7;

    localparam logic [1:0] SHADE_GRAY  = 2'h0;
    localparam logic [1:0] SHADE_DARK1 = 2'h1;
    localparam logic [1:0] SHADE_DARK2 = 2'h2;
    localparam logic [1:0] SHADE_BLACK = 2'h3;

    localparam logic [1:0] IMAP_IGNORE     = 2'h0;
    localparam logic [1:0] IMAP_UNDERSCORE = 2'h1;
    localparam logic [1:0] IMAP_REVERSE    = 2'h2;
    localparam logic [1:0] IMAP_ALTFONT    = 2'h3;

    localparam logic [2:0] UNDERLINE_ROW = 3'h7;

endpackage

`default_nettype wire

// *** core/lasm_refresh_buf.sv ***
`default_nettype none

// two byte banks: even bank holds characters, odd bank attributes
module lasm_refresh_buf
    import lasm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [13:0] buf_addr,
    input  wire logic [7:0]  buf_wdata,
    input  wire logic        buf_wr,
    input  wire logic        buf_rd,
    output logic      [7:0]  buf_rdata,
    input  wire logic [12:0] disp_addr,
    output logic      [15:0] disp_word
);

    logic [7:0] bank_byte [2];
    logic       rd_odd_q;
    logic       rd_q;

    // separate host and display ports: neither ever stalls the other
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            logic [7:0] mem [8192];
            logic [7:0] host_q;
            logic [7:0] disp_q;
            wire        sel_w = (buf_addr[0] == 1'(b)); // see R17
            always_ff @(posedge clock) begin
                if (buf_wr && sel_w) begin
                    mem[buf_addr[13:1]] <= buf_wdata; // see R9
                end
                host_q <= mem[buf_addr[13:1]];
                disp_q <= mem[disp_addr]; // see R8
            end
            assign bank_byte[b]             = host_q;
            assign disp_word[8*b +: 8]      = disp_q;
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_q     <= 1'b0;
            rd_odd_q <= 1'b0;
        end else begin
            rd_q     <= buf_rd;
            rd_odd_q <= buf_addr[0];
        end
    end

    assign buf_rdata = rd_q ? bank_byte[rd_odd_q] : 8'h00;

endmodule

`default_nettype wire

// *** core/lasm_text_shade.sv ***
`default_nettype none

module lasm_text_shade
    import lasm_pkg::*;
(
    input  wire logic [7:0] attr,
    input  wire logic       glyph_on,
    input  wire logic       underline_row,
    input  wire logic       mono_mode,
    input  wire logic [1:0] imap,
    output logic      [1:0] shade
);

    wire [2:0] fg_w     = attr[ATTR_FG_LSB +: 3]; // see R16 R18
    wire [2:0] bg_w     = attr[ATTR_BG_LSB +: 3];
    wire       int_w    = attr[ATTR_INT_BIT];
    wire       normal_w = (fg_w == COLOR_WHITE) && (bg_w == COLOR_BLACK); // see R1
    wire       blank_w  = (fg_w == COLOR_BLACK) && (bg_w == COLOR_BLACK); // see R5
    wire       same_w   = (fg_w == bg_w);
    wire       m_ul_w   = (bg_w == COLOR_BLACK) && (fg_w == COLOR_BLUE);  // see R19
    wire       m_rev_w  = (bg_w == COLOR_WHITE) && (fg_w == COLOR_BLACK);
    wire       m_blk_w  = (bg_w == COLOR_WHITE) && (fg_w == COLOR_WHITE);

    // mono pairs outside the table fall back to normal video
    wire solid_gray_w  = blank_w;                                          // see R5
    wire solid_black_w = mono_mode ? m_blk_w : (same_w && !blank_w);       // see R4
    wire reversed_w    = mono_mode ? m_rev_w : (!normal_w && !same_w);     // see R2 R3
    // intensity only picks a display attribute, never a darker ink
    wire rev_eff_w     = reversed_w ^ (int_w && imap == IMAP_REVERSE);     // see R14 R15
    wire ul_eff_w      = (mono_mode && m_ul_w) || (int_w && imap == IMAP_UNDERSCORE);
    wire ink_w         = glyph_on || (ul_eff_w && underline_row);
    wire dark_w        = solid_black_w ? 1'b1 : solid_gray_w ? 1'b0 : (ink_w ^ rev_eff_w);

    // text uses only two panel shades
    assign shade = dark_w ? SHADE_BLACK : SHADE_GRAY; // see R13

endmodule

`default_nettype wire

// *** tb/lasm_host_model.sv ***
`default_nettype none

module lasm_host_model
    import lasm_pkg::*;
(
    input  wire logic        clock,
    output logic      [9:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata,
    output logic      [13:0] buf_addr,
    output logic      [7:0]  buf_wdata,
    output logic             buf_wr,
    output logic             buf_rd,
    input  wire logic [7:0]  buf_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {reg_wr, reg_rd, buf_wr, buf_rd} = 4'h0;
        reg_addr  = 10'h000;
        reg_wdata = 8'h00;
        buf_addr  = 14'h0000;
        buf_wdata = 8'h00;
    end

    // released lines flip so a stale value never passes for a fresh one
    task automatic release_bus();
        {reg_wr, reg_rd, buf_wr, buf_rd} <= 4'h0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
        buf_addr  <= ~buf_addr;
        buf_wdata <= ~buf_wdata;
    endtask

    // a write leaves its strobe up so another access may follow at once;
    // a read releases the bus and takes its data one cycle after acceptance
    task automatic access(input logic sel_reg, input logic is_wr, input logic [13:0] addr,
                          input logic [7:0] wdata, output logic [7:0] rdata);
        reg_wr    <= sel_reg & is_wr;
        reg_rd    <= sel_reg & !is_wr;
        buf_wr    <= !sel_reg & is_wr;
        buf_rd    <= !sel_reg & !is_wr;
        reg_addr  <= addr[9:0];
        buf_addr  <= addr;
        reg_wdata <= wdata;
        buf_wdata <= wdata;
        @(posedge clock);
        rdata = 8'h00;
        if (!is_wr) begin
            release_bus();
            @(posedge clock);
            rdata = sel_reg ? reg_rdata : buf_rdata;
        end
    endtask

endmodule

`default_nettype wire

// *** tb/test_lcd_attribute_shade_mapper.sv ***
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_lcd_attribute_shade_mapper
    import lasm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        rst;
    logic        mono_range;
    logic [9:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [13:0] buf_addr;
    logic [7:0]  buf_wdata;
    logic        buf_wr;
    logic        buf_rd;
    logic [7:0]  buf_rdata;
    logic [1:0]  pel_shade;
    logic        pel_valid;
    logic        line_start;
    logic        frame_start;
    logic [7:0]  rd;
    logic [9:0]  base;
    logic [15:0] gpat;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          prev_line = 0;
    int          cnt;
    int          vis;

    lasm_top u_dut (
        .clock(clock), .rst(rst), .mono_range(mono_range),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
        .buf_wr(buf_wr), .buf_rd(buf_rd), .buf_rdata(buf_rdata), .pel_shade(pel_shade),
        .pel_valid(pel_valid), .line_start(line_start), .frame_start(frame_start)
    );

    lasm_host_model u_host (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_addr(buf_addr),
        .buf_wdata(buf_wdata), .buf_wr(buf_wr), .buf_rd(buf_rd), .buf_rdata(buf_rdata)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // index of the line whose first pel showed in the previous cycles
    always @(posedge clock) begin
        if (line_start) begin
            prev_line <= frame_start ? 0 : prev_line + 1;
        end
    end

    task automatic give_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the run must end well inside the 200 active lines of the first frame
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            give_verdict();
        end
    end

    function automatic logic [9:0] ra(input logic [3:0] off);
        return {base[9:4], off};
    endfunction

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        u_host.access(1'b1, 1'b1, {4'h0, a}, d, rd);
    endtask

    task automatic rd_reg(input logic [9:0] a, output logic [7:0] q);
        u_host.access(1'b1, 1'b0, {4'h0, a}, 8'h00, q);
    endtask

    // skips at least one line boundary so fresh cell data is fetched, until the glyph row is 7 exactly when want7 is set, then captures pels 0..7
    task automatic grab(input logic want7, output logic [15:0] got);
        int n;
        int seen;
        int line;
        n = 0;
        seen = 0;
        while (n < 20000) begin
            @(posedge clock);
            #1;
            n++;
            if (line_start) begin
                line = frame_start ? 0 : prev_line + 1;
                seen++;
                if (seen > 1 && ((line % 8) == 7) == want7) break;
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (i > 0) begin
                @(posedge clock);
                #1;
            end
            got[2*i +: 2] = pel_shade;
        end
    endtask

    // char 1 with the given attribute in column 0 of all 25 rows
    task automatic shade_case(input logic [7:0] mode, input logic [7:0] attr,
                              input logic want7, input logic [15:0] exp);
        logic [15:0] got;
        wr_reg(ra(REG_MODE), mode); // video bit kept set while cells change
        for (int r = 0; r < 25; r++) begin
            u_host.access(1'b0, 1'b1, 14'(r * 160), 8'h01, rd);
            u_host.access(1'b0, 1'b1, 14'(r * 160 + 1), attr, rd);
        end
        u_host.release_bus();
        grab(want7, got);
        `CHK(got, exp)
    endtask

    // glyph 3C lights pels 2..5, C3 pels 0,1,6,7; symmetric so bit order cannot matter
    localparam logic [15:0] NORM = 16'h0FF0;
    localparam logic [15:0] REV  = 16'hF00F;

    initial begin
        rst = 1'b1;
        mono_range = 1'b0;
        base = COLOR_BASE;
        repeat (10) @(posedge clock);
        `CHK({reg_rdata, buf_rdata, pel_shade, pel_valid, line_start, frame_start}, 21'h0)
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        cnt = 0;
        while (!frame_start && cnt < 10) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        `CHK(frame_start & line_start, 1'b1)
        cnt = 0;
        vis = 1;
        do begin
            @(posedge clock);
            #1;
            cnt++;
            if (!line_start) vis += pel_valid;
        end while (!line_start && cnt < 1000);
        `CHK(cnt, H_TOTAL)
        `CHK(vis, H_ACTIVE)
        rd_reg(ra(REG_MODE), rd);
        `CHK(rd, MODE_RESET)
        rd_reg({MONO_BASE[9:4], REG_MODE}, rd);
        `CHK(rd, 8'h00)
        wr_reg({MONO_BASE[9:4], REG_MODE}, 8'hFF);
        rd_reg(ra(4'hF), rd);
        `CHK(rd, 8'h00)
        rd_reg(ra(REG_MODE), rd);
        `CHK(rd, MODE_RESET)
        mono_range <= 1'b1;
        base = MONO_BASE;
        rd_reg(ra(REG_MODE), rd);
        `CHK(rd, MODE_RESET)
        rd_reg({COLOR_BASE[9:4], REG_MODE}, rd);
        `CHK(rd, 8'h00)
        mono_range <= 1'b0;
        base = COLOR_BASE;
        u_host.access(1'b0, 1'b1, 14'h3FF0, 8'h5A, rd);
        u_host.access(1'b0, 1'b0, 14'h3FF0, 8'h00, rd);
        `CHK(rd, 8'h5A)
        u_host.access(1'b0, 1'b1, 14'h3FF1, 8'hA5, rd);
        u_host.access(1'b0, 1'b0, 14'h3FF0, 8'h00, rd);
        `CHK(rd, 8'h5A)
        u_host.access(1'b0, 1'b0, 14'h3FF1, 8'h00, rd);
        `CHK(rd, 8'hA5)
        wr_reg(ra(REG_FONT_LO), 8'h08);
        wr_reg(ra(REG_FONT_HI), 8'h00);
        repeat (8) wr_reg(ra(REG_FONT_DATA), 8'h3C);
        wr_reg(ra(REG_FONT_LO), 8'h08);
        wr_reg(ra(REG_FONT_HI), 8'h08);
        repeat (8) wr_reg(ra(REG_FONT_DATA), 8'hC3);
        rd_reg(ra(REG_FONT_LO), rd);
        `CHK(rd, 8'h10)
        wr_reg(ra(REG_MODE), 8'h00);
        u_host.release_bus();
        grab(1'b0, gpat);
        `CHK(gpat, 16'h0000)
        for (int c = 0; c < 8; c++) begin
            shade_case(8'h04, 8'(c), 1'b0, c == 7 ? NORM : c == 0 ? 16'h0000 : REV);
        end
        shade_case(8'h04, 8'h70, 1'b0, REV);
        shade_case(8'h04, 8'h12, 1'b0, REV);
        shade_case(8'h04, 8'h44, 1'b0, 16'hFFFF);
        shade_case(8'h04, 8'h0F, 1'b0, NORM);
        shade_case(8'h0C, 8'h0F, 1'b1, 16'hFFFF);
        shade_case(8'h14, 8'h0F, 1'b0, REV);
        shade_case(8'h1C, 8'h0F, 1'b0, REV);
        shade_case(8'h06, 8'h00, 1'b0, 16'h0000);
        shade_case(8'h06, 8'h01, 1'b1, 16'hFFFF);
        shade_case(8'h06, 8'h01, 1'b0, NORM);
        shade_case(8'h06, 8'h07, 1'b0, NORM);
        shade_case(8'h06, 8'h70, 1'b0, REV);
        shade_case(8'h06, 8'h77, 1'b0, 16'hFFFF);
        wr_reg(ra(REG_MODE), 8'h05);
        for (int y = 0; y < V_ACTIVE; y++) begin
            u_host.access(1'b0, 1'b1, 14'(y * TEXT_COLS), 8'h1B, rd);
        end
        u_host.release_bus();
        grab(1'b0, gpat);
        `CHK(gpat, 16'hFA50)
        rd_reg(ra(REG_STATUS), rd);
        `CHK(rd, 8'h05)
        rd_reg(ra(REG_LINE), rd);
        `CHK(rd, 8'(prev_line))
        give_verdict();
    end

endmodule

`default_nettype wire
